// ==== iod_pkg.sv ====
/*
  Package for the lower I/O space decoder: addresses, masks, request and
  event carriers. Assumes a core that issues one request per clock.
*/
package iod_pkg;

  // ==========================================================
  // Address space
  localparam logic [7:0] IOD_DS_OFS  = 8'h20;
  localparam logic [7:0] IOD_EXT_LO  = 8'h60;
  localparam logic [5:0] IOD_BIT_TOP = 6'h1F;
  localparam logic [7:0] IOD_RST     = 8'h00;

  localparam logic [5:0] IOD_A_RSV0       = 6'h01;
  localparam logic [5:0] IOD_A_PORT_B_PIN = 6'h03;
  localparam logic [5:0] IOD_A_PORT_B_DIR = 6'h04;
  localparam logic [5:0] IOD_A_PORT_B_OUT = 6'h05;
  localparam logic [5:0] IOD_A_PORT_C_PIN = 6'h06;
  localparam logic [5:0] IOD_A_PORT_C_DIR = 6'h07;
  localparam logic [5:0] IOD_A_PORT_C_OUT = 6'h08;
  localparam logic [5:0] IOD_A_PORT_D_PIN = 6'h09;
  localparam logic [5:0] IOD_A_PORT_D_DIR = 6'h0A;
  localparam logic [5:0] IOD_A_PORT_D_OUT = 6'h0B;
  localparam logic [5:0] IOD_A_T0_FLAGS   = 6'h15;
  localparam logic [5:0] IOD_A_T2_FLAGS   = 6'h17;
  localparam logic [5:0] IOD_A_PC_FLAGS   = 6'h1B;
  localparam logic [5:0] IOD_A_EXT_FLAGS  = 6'h1C;
  localparam logic [5:0] IOD_A_EXT_MASK   = 6'h1D;
  localparam logic [5:0] IOD_A_GPR0       = 6'h1E;
  localparam logic [5:0] IOD_A_EE_CTRL    = 6'h1F;
  localparam logic [5:0] IOD_A_EE_DATA    = 6'h20;
  localparam logic [5:0] IOD_A_EE_ADDR_LO = 6'h21;
  localparam logic [5:0] IOD_A_EE_ADDR_HI = 6'h22;
  localparam logic [5:0] IOD_A_PRESC_SYNC = 6'h23;
  localparam logic [5:0] IOD_A_T0_CTRL_A  = 6'h24;
  localparam logic [5:0] IOD_A_T0_CTRL_B  = 6'h25;
  localparam logic [5:0] IOD_A_T0_COUNT   = 6'h26;
  localparam logic [5:0] IOD_A_T0_CMP_A   = 6'h27;
  localparam logic [5:0] IOD_A_T0_CMP_B   = 6'h28;
  localparam logic [5:0] IOD_A_GPR1       = 6'h2A;
  localparam logic [5:0] IOD_A_GPR2       = 6'h2B;
  localparam logic [5:0] IOD_A_SP_CTRL    = 6'h2C;
  localparam logic [5:0] IOD_A_SP_STAT    = 6'h2D;
  localparam logic [5:0] IOD_A_SP_DATA    = 6'h2E;
  localparam logic [5:0] IOD_A_CMP_CS     = 6'h30;
  localparam logic [5:0] IOD_A_SLEEP      = 6'h33;

  // ==========================================================
  // Field positions
  localparam int IOD_FORCE_HI  = 7;
  localparam int IOD_FORCE_LO  = 6;
  localparam int IOD_ACI_BIT   = 4;
  localparam int IOD_ACO_BIT   = 5;
  localparam logic [7:0] IOD_EE_STROBES = 8'h03;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    IOD_OP_NONE     = 4'b0000,
    IOD_OP_IO_RD    = 4'b0001,
    IOD_OP_IO_WR    = 4'b0010,
    IOD_OP_BIT_SET  = 4'b0011,
    IOD_OP_BIT_CLR  = 4'b0100,
    IOD_OP_SKIP_SET = 4'b0101,
    IOD_OP_SKIP_CLR = 4'b0110,
    IOD_OP_DS_RD    = 4'b0111,
    IOD_OP_DS_WR    = 4'b1000
  } iod_op_t;

  typedef struct packed {
    iod_op_t    op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_sel;
  } iod_req_t;

  typedef struct packed {
    logic [2:0] timer0;
    logic [2:0] timer2;
    logic [2:0] pin_change;
    logic [1:0] ext_int;
    logic       comparator;
    logic       eeprom_done;
  } iod_evt_t;

  typedef struct packed {
    logic [7:0] port_b_dir;
    logic [7:0] port_b_out;
    logic [7:0] port_c_dir;
    logic [7:0] port_c_out;
    logic [7:0] port_d_dir;
    logic [7:0] port_d_out;
    logic [7:0] ext_mask;
    logic [7:0] ee_ctrl;
    logic [7:0] ee_data;
    logic [7:0] ee_addr_lo;
    logic [7:0] ee_addr_hi;
    logic [7:0] presc_sync;
    logic [7:0] t0_ctrl_a;
    logic [7:0] t0_ctrl_b;
    logic [7:0] t0_count;
    logic [7:0] t0_cmp_a;
    logic [7:0] t0_cmp_b;
    logic [7:0] sp_ctrl;
    logic [7:0] sp_stat;
    logic [7:0] sp_data;
    logic [7:0] cmp_cs;
    logic [7:0] sleep;
  } iod_ctrl_t;

  // ==========================================================
  // Per-address masks: software-writable, write-one-to-clear, read-only
  function automatic logic [7:0] iod_wmask(input logic [5:0] a);
    case (a)
      IOD_A_PORT_B_DIR, IOD_A_PORT_B_OUT, IOD_A_PORT_D_DIR,
      IOD_A_PORT_D_OUT, IOD_A_GPR0, IOD_A_EE_DATA, IOD_A_EE_ADDR_LO,
      IOD_A_EE_ADDR_HI, IOD_A_T0_COUNT, IOD_A_T0_CMP_A, IOD_A_T0_CMP_B,
      IOD_A_GPR1, IOD_A_GPR2, IOD_A_SP_CTRL, IOD_A_SP_DATA: iod_wmask = 8'hFF;
      IOD_A_PORT_C_DIR, IOD_A_PORT_C_OUT: iod_wmask = 8'h7F;
      IOD_A_EXT_MASK:   iod_wmask = 8'h03;
      IOD_A_EE_CTRL:    iod_wmask = 8'h3F;
      IOD_A_PRESC_SYNC: iod_wmask = 8'h83;
      IOD_A_T0_CTRL_A:  iod_wmask = 8'hF3;
      IOD_A_T0_CTRL_B:  iod_wmask = 8'h0F;
      IOD_A_SP_STAT:    iod_wmask = 8'h01;
      IOD_A_CMP_CS:     iod_wmask = 8'hCF;
      IOD_A_SLEEP:      iod_wmask = 8'h0F;
      default:          iod_wmask = 8'h00;
    endcase
  endfunction : iod_wmask

  function automatic logic [7:0] iod_cmask(input logic [5:0] a);
    case (a)
      IOD_A_T0_FLAGS, IOD_A_T2_FLAGS, IOD_A_PC_FLAGS: iod_cmask = 8'h07;
      IOD_A_EXT_FLAGS: iod_cmask = 8'h03;
      IOD_A_CMP_CS:    iod_cmask = 8'h10;
      default:         iod_cmask = 8'h00;
    endcase
  endfunction : iod_cmask

  function automatic logic [7:0] iod_romask(input logic [5:0] a);
    case (a)
      IOD_A_PORT_B_PIN, IOD_A_PORT_D_PIN: iod_romask = 8'hFF;
      IOD_A_PORT_C_PIN: iod_romask = 8'h7F;
      IOD_A_SP_STAT:    iod_romask = 8'hC0;
      IOD_A_CMP_CS:     iod_romask = 8'h20;
      default:          iod_romask = 8'h00;
    endcase
  endfunction : iod_romask

endpackage : iod_pkg

// ==== iod_sync.sv ====
/*
  Two-flop synchroniser for pin levels.
  Assumes inputs are static levels from outside the clock domain.
*/
`timescale 1ns/1ps
module iod_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : iod_sync

// ==== iod_io_space.sv ====
/*
  Lower I/O register space (64 locations) with bit access, data-space
  alias and forwarding of extended I/O to outside logic.
  Assumes one core request per clock and same-clock extended-I/O logic
  that answers reads combinationally on ext_rdata.
*/
`timescale 1ns/1ps

// Function
// - Short I/O instructions address the 64 locations 0x00 to 0x3F.
// - Data-space loads and stores see each I/O register at address plus 0x20.
// - Single-bit set and clear work on 0x00-0x1F and do nothing elsewhere.
// - Skip-on-bit instructions read one chosen bit of a bit-accessible register.
// - Status flags clear on writing one; writing zero leaves them alone.
// - Bit set or clear touches only the addressed bit, never other flags.
// - Extended registers 0x60-0xFF are reached only by data-space accesses.
module iod_io_space
  import iod_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  iod_req_t        req,
  input  wire logic [7:0] pin_b,
  input  wire logic [6:0] pin_c,
  input  wire logic [7:0] pin_d,
  input  wire logic       comparator_out,
  input  iod_evt_t        evt,
  input  wire logic       spi_flag,
  input  wire logic       spi_collision,
  input  wire logic [7:0] ext_rdata,
  output logic            rvalid_q,
  output logic      [7:0] rdata_q,
  output logic            bit_q,
  output logic            skip_q,
  output logic      [1:0] force_cmp_q,
  output logic            ext_re,
  output logic            ext_we,
  output logic      [7:0] ext_addr,
  output logic      [7:0] ext_wdata,
  output iod_ctrl_t       ctrl
);

  // ==========================================================
  // Pin synchronisers
  logic [7:0] pin_b_s;
  logic [6:0] pin_c_s;
  logic [7:0] pin_d_s;
  logic       aco_s;

  iod_sync #(.W(24)) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({comparator_out, pin_d, pin_c, pin_b}),
    .sync_out ({aco_s, pin_d_s, pin_c_s, pin_b_s})
  );

  // ==========================================================
  // Request decode
  wire       is_io    = (req.op == IOD_OP_IO_RD) || (req.op == IOD_OP_IO_WR) ||
                        (req.op == IOD_OP_BIT_SET) || (req.op == IOD_OP_BIT_CLR) ||
                        (req.op == IOD_OP_SKIP_SET) || (req.op == IOD_OP_SKIP_CLR);
  wire       is_ds    = (req.op == IOD_OP_DS_RD) || (req.op == IOD_OP_DS_WR);
  wire       is_bwr   = (req.op == IOD_OP_BIT_SET) || (req.op == IOD_OP_BIT_CLR);
  wire       is_skip  = (req.op == IOD_OP_SKIP_SET) || (req.op == IOD_OP_SKIP_CLR);
  // Window 0x20-0x5F aliases the I/O space; 8-bit address tops out at 0xFF
  wire       ds_in_io = is_ds && (req.addr >= IOD_DS_OFS) &&
                        (req.addr < IOD_EXT_LO);
  wire       ds_ext   = is_ds && (req.addr >= IOD_EXT_LO);
  // Short I/O form carries six address bits only
  wire [5:0] idx      = is_io ? req.addr[5:0] :
                        6'(req.addr - IOD_DS_OFS);
  wire       bit_ok   = idx <= IOD_BIT_TOP;
  wire       byte_wr  = (req.op == IOD_OP_IO_WR) ||
                        ((req.op == IOD_OP_DS_WR) && ds_in_io);
  wire       bit_wr   = is_bwr && bit_ok;
  wire       rd_hit   = (req.op == IOD_OP_IO_RD) ||
                        ((req.op == IOD_OP_DS_RD) && ds_in_io);
  wire       any_rd   = (req.op == IOD_OP_IO_RD) || (req.op == IOD_OP_DS_RD) ||
                        is_skip;
  wire [7:0] onehot   = 8'(8'h01 << req.bit_sel);

  assign ext_re    = (req.op == IOD_OP_DS_RD) && ds_ext;
  assign ext_we    = (req.op == IOD_OP_DS_WR) && ds_ext;
  assign ext_addr  = req.addr;
  assign ext_wdata = req.wdata;

  // ==========================================================
  // Hardware sources per address
  logic [7:0] reg_q   [64];
  logic [7:0] rd_word [64];
  logic [7:0] hw_set  [64];
  logic [7:0] hw_clr  [64];
  logic [7:0] ro_src  [64];

  always_comb begin
    hw_set = '{default: IOD_RST};
    hw_clr = '{default: IOD_RST};
    ro_src = '{default: IOD_RST};
    hw_set[IOD_A_T0_FLAGS]  = {5'h00, evt.timer0};
    hw_set[IOD_A_T2_FLAGS]  = {5'h00, evt.timer2};
    hw_set[IOD_A_PC_FLAGS]  = {5'h00, evt.pin_change};
    hw_set[IOD_A_EXT_FLAGS] = {6'h00, evt.ext_int};
    hw_set[IOD_A_CMP_CS][IOD_ACI_BIT] = evt.comparator;
    hw_clr[IOD_A_EE_CTRL]   = evt.eeprom_done ? IOD_EE_STROBES : IOD_RST;
    ro_src[IOD_A_PORT_B_PIN] = pin_b_s;
    ro_src[IOD_A_PORT_C_PIN] = {1'b0, pin_c_s};
    ro_src[IOD_A_PORT_D_PIN] = pin_d_s;
    ro_src[IOD_A_SP_STAT]    = {spi_flag, spi_collision, 6'h00};
    ro_src[IOD_A_CMP_CS][IOD_ACO_BIT] = aco_s;
  end

  // ==========================================================
  // Write data for byte and single-bit writes
  wire [7:0] cur_raw = reg_q[idx];
  wire [7:0] cur     = rd_word[idx];
  wire [7:0] wr_val  = byte_wr ? req.wdata :
                       (req.op == IOD_OP_BIT_SET) ? (cur_raw | onehot) :
                       (cur_raw & ~onehot);
  // Bit set hands the flag logic only the addressed bit; bit clear hands it none
  wire [7:0] clr_src = byte_wr ? req.wdata :
                       (req.op == IOD_OP_BIT_SET) ? onehot : IOD_RST;

  // ==========================================================
  // Register array, one entry per I/O address
  genvar a;
  generate
    for (a = 0; a < 64; a++) begin : g_reg
      localparam logic [7:0] WM = iod_wmask(6'(a));
      localparam logic [7:0] CM = iod_cmask(6'(a));
      localparam logic [7:0] RM = iod_romask(6'(a));
      wire       sel    = (byte_wr || bit_wr) && (idx == 6'(a));
      wire [7:0] sw_clr = sel ? (clr_src & CM) : IOD_RST;
      wire [7:0] base   = reg_q[a] & ~hw_clr[a];
      // Reserved locations have all-zero masks: writes fall away
      wire [7:0] wr_mix = sel ? ((base & ~WM) | (wr_val & WM)) : base;
      // Hardware set wins over a software clear in the same cycle
      wire [7:0] reg_d  = (wr_mix & ~sw_clr) | (hw_set[a] & CM);

      always_ff @(posedge clk) begin
        if (!rstn) begin
          reg_q[a] <= IOD_RST;
        end else begin
          reg_q[a] <= reg_d;
        end
      end

      assign rd_word[a] = (reg_q[a] & (WM | CM)) | (ro_src[a] & RM);
    end
  endgenerate

  // ==========================================================
  // Read answer, bit test and force strobes
  wire       bit_val = cur[req.bit_sel];
  wire [7:0] rd_mux  = ds_ext ? ext_rdata : (rd_hit ? cur : IOD_RST);
  wire       skip_d  = is_skip && bit_ok &&
                       ((req.op == IOD_OP_SKIP_SET) ? bit_val : !bit_val);
  wire [1:0] force_d = (byte_wr && (idx == IOD_A_T0_CTRL_B)) ?
                       req.wdata[IOD_FORCE_HI:IOD_FORCE_LO] : 2'b00;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rvalid_q    <= 1'b0;
      rdata_q     <= IOD_RST;
      bit_q       <= 1'b0;
      skip_q      <= 1'b0;
      force_cmp_q <= 2'b00;
    end else begin
      rvalid_q    <= any_rd;
      rdata_q     <= is_skip ? IOD_RST : rd_mux;
      bit_q       <= is_skip && bit_ok && bit_val;
      skip_q      <= skip_d;
      force_cmp_q <= force_d;
    end
  end

  // ==========================================================
  // Control image toward the peripherals
  assign ctrl.port_b_dir = reg_q[IOD_A_PORT_B_DIR];
  assign ctrl.port_b_out = reg_q[IOD_A_PORT_B_OUT];
  assign ctrl.port_c_dir = reg_q[IOD_A_PORT_C_DIR];
  assign ctrl.port_c_out = reg_q[IOD_A_PORT_C_OUT];
  assign ctrl.port_d_dir = reg_q[IOD_A_PORT_D_DIR];
  assign ctrl.port_d_out = reg_q[IOD_A_PORT_D_OUT];
  assign ctrl.ext_mask   = reg_q[IOD_A_EXT_MASK];
  assign ctrl.ee_ctrl    = reg_q[IOD_A_EE_CTRL];
  assign ctrl.ee_data    = reg_q[IOD_A_EE_DATA];
  assign ctrl.ee_addr_lo = reg_q[IOD_A_EE_ADDR_LO];
  assign ctrl.ee_addr_hi = reg_q[IOD_A_EE_ADDR_HI];
  assign ctrl.presc_sync = reg_q[IOD_A_PRESC_SYNC];
  assign ctrl.t0_ctrl_a  = reg_q[IOD_A_T0_CTRL_A];
  assign ctrl.t0_ctrl_b  = reg_q[IOD_A_T0_CTRL_B];
  assign ctrl.t0_count   = reg_q[IOD_A_T0_COUNT];
  assign ctrl.t0_cmp_a   = reg_q[IOD_A_T0_CMP_A];
  assign ctrl.t0_cmp_b   = reg_q[IOD_A_T0_CMP_B];
  assign ctrl.sp_ctrl    = reg_q[IOD_A_SP_CTRL];
  assign ctrl.sp_stat    = reg_q[IOD_A_SP_STAT];
  assign ctrl.sp_data    = reg_q[IOD_A_SP_DATA];
  assign ctrl.cmp_cs     = reg_q[IOD_A_CMP_CS];
  assign ctrl.sleep      = reg_q[IOD_A_SLEEP];

  // ==========================================================
  // Assertions
  localparam logic [7:0] DS_GPR0 = {2'b00, IOD_A_GPR0} + IOD_DS_OFS;

  property p_io_rd_data;
    @(posedge clk) disable iff (!rstn)
    (req.op == IOD_OP_IO_RD) && (req.addr[5:0] == IOD_A_GPR0)
      |=> rvalid_q && (rdata_q == $past(reg_q[IOD_A_GPR0]));
  endproperty
  a_io_rd_data: assert property (p_io_rd_data) else $error("io read data wrong");

  property p_ds_alias;
    @(posedge clk) disable iff (!rstn)
    (req.op == IOD_OP_DS_WR) && (req.addr == DS_GPR0)
      |=> reg_q[IOD_A_GPR0] == $past(req.wdata);
  endproperty
  a_ds_alias: assert property (p_ds_alias) else $error("data-space alias missed");

  property p_bit_range;
    @(posedge clk) disable iff (!rstn)
    is_bwr && (req.addr[5:0] > IOD_BIT_TOP) |-> !bit_wr;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit op beyond 0x1F");

  property p_bit_set;
    @(posedge clk) disable iff (!rstn)
    (req.op == IOD_OP_BIT_SET) && (req.addr[5:0] == IOD_A_PORT_B_OUT)
      |=> reg_q[IOD_A_PORT_B_OUT][$past(req.bit_sel)];
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set had no effect");

  property p_skip;
    @(posedge clk) disable iff (!rstn)
    (req.op == IOD_OP_SKIP_CLR) && bit_ok
      |=> rvalid_q && (skip_q == !bit_q) && (bit_q == $past(bit_val));
  endproperty
  a_skip: assert property (p_skip) else $error("skip bit wrong");

  property p_w1c_zero;
    @(posedge clk) disable iff (!rstn)
    byte_wr && (idx == IOD_A_T0_FLAGS) && (req.wdata == IOD_RST) &&
      reg_q[IOD_A_T0_FLAGS][0] |=> reg_q[IOD_A_T0_FLAGS][0];
  endproperty
  a_w1c_zero: assert property (p_w1c_zero) else $error("zero write cleared flag");

  property p_w1c_one;
    @(posedge clk) disable iff (!rstn)
    byte_wr && (idx == IOD_A_T0_FLAGS) && req.wdata[0] && !evt.timer0[0]
      |=> !reg_q[IOD_A_T0_FLAGS][0];
  endproperty
  a_w1c_one: assert property (p_w1c_one) else $error("one write kept flag");

  property p_set_wins;
    @(posedge clk) disable iff (!rstn)
    evt.timer0[0] |=> reg_q[IOD_A_T0_FLAGS][0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag event lost");

  property p_bit_only;
    @(posedge clk) disable iff (!rstn)
    (req.op == IOD_OP_BIT_SET) && (req.addr[5:0] == IOD_A_T0_FLAGS) &&
      (req.bit_sel == 3'h0) && (evt.timer0 == 3'h0)
      |=> reg_q[IOD_A_T0_FLAGS][2:1] == $past(reg_q[IOD_A_T0_FLAGS][2:1]);
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("bit op hit other flags");

  property p_ext_only;
    @(posedge clk) disable iff (!rstn)
    is_io |-> !ext_re && !ext_we;
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("io op reached ext space");

  property p_ext_ds;
    @(posedge clk) disable iff (!rstn)
    (req.op == IOD_OP_DS_WR) && (req.addr >= IOD_EXT_LO) |-> ext_we;
  endproperty
  a_ext_ds: assert property (p_ext_ds) else $error("ext store not forwarded");

  property p_reserved;
    @(posedge clk) disable iff (!rstn)
    (req.op == IOD_OP_IO_RD) && (req.addr[5:0] == IOD_A_RSV0)
      |=> rvalid_q && (rdata_q == IOD_RST);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved read not zero");

  property p_ds_low;
    @(posedge clk) disable iff (!rstn)
    (req.op == IOD_OP_DS_RD) && (req.addr < IOD_DS_OFS)
      |=> rvalid_q && (rdata_q == IOD_RST);
  endproperty
  a_ds_low: assert property (p_ds_low) else $error("low data read not zero");

  property p_bit_clr;
    @(posedge clk) disable iff (!rstn)
    (req.op == IOD_OP_BIT_CLR) && (req.addr[5:0] == IOD_A_PORT_B_OUT)
      |=> !reg_q[IOD_A_PORT_B_OUT][$past(req.bit_sel)];
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("bit clear had no effect");

  property p_ext_rd;
    @(posedge clk) disable iff (!rstn)
    (req.op == IOD_OP_DS_RD) && (req.addr >= IOD_EXT_LO)
      |-> ext_re ##1 (rdata_q == $past(ext_rdata));
  endproperty
  a_ext_rd: assert property (p_ext_rd) else $error("ext read not returned");

endmodule : iod_io_space

// ==== iod_core_model.sv ====
/*
  Core-side model for the I/O space decoder: issues one request per call, none for writes to unused addresses unless bad is set.
  Assumes answers registered on the taking edge, read half a cycle later, and combinational ext strobes.
*/
`timescale 1ns/1ps
module iod_core_model
  import iod_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rvalid_q,
  input  wire logic [7:0] rdata_q,
  input  wire logic       bit_q,
  input  wire logic       skip_q,
  input  wire logic       ext_we,
  output iod_req_t        req
);
  // ==========================================================
  // Software view of the map: bits in use per I/O address
  function automatic logic [7:0] used_bits(input logic [5:0] a);
    case (a)
      6'h00, 6'h01, 6'h02, 6'h16, 6'h18, 6'h19, 6'h1A, 6'h29, 6'h2F, 6'h31,
      6'h32: used_bits = 8'h00;
      6'h07, 6'h08: used_bits = 8'h7F;
      6'h15, 6'h17, 6'h1B: used_bits = 8'h07;
      6'h1C, 6'h1D: used_bits = 8'h03;
      6'h1F: used_bits = 8'h3F;
      6'h23: used_bits = 8'h83;
      6'h24: used_bits = 8'hF3;
      6'h25: used_bits = 8'hCF;
      6'h2D: used_bits = 8'hC1;
      6'h33: used_bits = 8'h0F;
      default: used_bits = (a > 6'h0B && a < 6'h15) ? 8'h00 : 8'hFF;
    endcase
  endfunction : used_bits

  initial req = '{IOD_OP_NONE, 8'h00, 8'h00, 3'h0};

  // ==========================================================
  // One transfer; bit ops take the bit index from d
  task automatic xfer(input iod_op_t op, input logic [7:0] a, input logic [7:0] d,
                      input bit bad, output logic [7:0] rd, output logic [3:0] fl);
    logic [5:0] ia;
    logic       sw;
    ia = (op == IOD_OP_DS_WR) ? 6'(a - 8'h20) : a[5:0];
    sw = (op == IOD_OP_IO_WR) || (op == IOD_OP_DS_WR && a >= 8'h20 && a < 8'h60);
    rd = 8'h00;
    fl = 4'h0;
    if (sw && !bad && used_bits(ia) == 8'h00)
      return;
    if (sw && !bad)
      d = d & used_bits(ia);
    @(negedge clk);
    req = '{op, a, d, d[2:0]};
    @(posedge clk);
    fl[3] = ext_we;
    @(negedge clk);
    req = '{IOD_OP_NONE, ~a, ~d, ~d[2:0]};
    rd = rdata_q;
    fl[2:0] = {rvalid_q, bit_q, skip_q};
  endtask : xfer
endmodule : iod_core_model

// ==== iod_io_space_tb.sv ====
/*
  Self-checking bench for the lower I/O space decoder.
  Assumes the core model drives req and the decoder holds its own assertions.
*/
`timescale 1ns/1ps
module iod_io_space_tb
  import iod_pkg::*;
;
  logic       clk;
  logic       rstn;
  iod_req_t   req;
  logic [7:0] pin_b;
  logic [6:0] pin_c;
  logic [7:0] pin_d;
  logic       comparator_out;
  iod_evt_t   evt;
  logic       spi_flag;
  logic       spi_collision;
  logic [7:0] ext_rdata;
  logic       rvalid_q, bit_q, skip_q, ext_we, ext_re;
  logic [1:0] force_cmp;
  logic [7:0] ext_addr, ext_wdata;
  logic [16:0] ext_seen;
  logic [7:0] rdata_q;
  iod_ctrl_t  ctrl;
  logic [7:0] rd;
  logic [3:0] fl;
  int         fails, check_count, cycles;

  iod_io_space u_iod_io_space (
    .clk(clk), .rstn(rstn), .req(req), .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d),
    .comparator_out(comparator_out), .evt(evt), .spi_flag(spi_flag),
    .spi_collision(spi_collision), .ext_rdata(ext_rdata), .rvalid_q(rvalid_q),
    .rdata_q(rdata_q), .bit_q(bit_q), .skip_q(skip_q), .force_cmp_q(force_cmp),
    .ext_re(ext_re), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ctrl(ctrl)
  );

  // Last extended-space access seen by the far side
  always @(posedge clk) begin
    if (ext_re || ext_we) ext_seen <= {ext_re, ext_addr, ext_wdata};
  end

  iod_core_model u_iod_core_model (
    .clk(clk), .rvalid_q(rvalid_q), .rdata_q(rdata_q), .bit_q(bit_q),
    .skip_q(skip_q), .ext_we(ext_we), .req(req)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end

  // ==========================================================
  // Report and compare
  task automatic results;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask : chk8

  // Flags: ext write strobe, read valid, tested bit, skip
  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: flags %b, want %b", $time, got, exp);
    end
  endtask : chk4

  task automatic io(input iod_op_t op, input logic [7:0] a, input logic [7:0] d = 8'h00,
                    input bit bad = 1'b0);
    u_iod_core_model.xfer(op, a, d, bad, rd, fl);
  endtask : io

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    io(IOD_OP_IO_RD, a);
    chk8(rd, exp);
  endtask : rdchk

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] a [5] = '{8'h04, 8'h1D, 8'h24, 8'h2C, 8'h33};
    foreach (a[i]) rdchk(a[i], 8'h00);
  endtask : t_reset

  task automatic t_pins;
    logic [7:0] a [5] = '{8'h03, 8'h06, 8'h09, 8'h30, 8'h2D};
    logic [7:0] e [5] = '{8'hC3, 8'h55, 8'h0F, 8'h20, 8'h81};
    io(IOD_OP_IO_WR, 8'h2D, 8'hFF);
    foreach (a[i]) rdchk(a[i], e[i]);
    io(IOD_OP_SKIP_SET, 8'h03, 8'h07);
    chk4(fl, 4'b0111);
  endtask : t_pins

  task automatic t_alias;
    io(IOD_OP_IO_WR, 8'h05, 8'hA5);
    chk8(ctrl.port_b_out, 8'hA5);
    io(IOD_OP_DS_RD, 8'h25);
    chk8(rd, 8'hA5);
    io(IOD_OP_DS_WR, 8'h4A, 8'h3C);
    rdchk(8'hEA, 8'h3C);
    io(IOD_OP_IO_WR, 8'h1E, 8'h77);
    io(IOD_OP_DS_RD, 8'h1E);
    chk8(rd, 8'h00);
  endtask : t_alias

  task automatic t_bits;
    io(IOD_OP_BIT_SET, 8'h05, 8'h01);
    io(IOD_OP_BIT_CLR, 8'h05, 8'h07);
    chk8(ctrl.port_b_out, 8'h27);
    io(IOD_OP_BIT_SET, 8'h2A, 8'h00);
    rdchk(8'h2A, 8'h3C);
  endtask : t_bits

  task automatic t_skip;
    io(IOD_OP_SKIP_SET, 8'h05, 8'h00);
    chk4(fl, 4'b0111);
    io(IOD_OP_SKIP_CLR, 8'h05, 8'h00);
    chk4(fl, 4'b0110);
    io(IOD_OP_SKIP_CLR, 8'h05, 8'h03);
    chk4(fl, 4'b0101);
    io(IOD_OP_SKIP_SET, 8'h2A, 8'h02);
    chk4(fl, 4'b0100);
  endtask : t_skip

  task automatic t_flags;
    @(negedge clk);
    evt = '{timer0: 3'h7, timer2: 3'h2, pin_change: 3'h4, ext_int: 2'h3, comparator: 1'b1,
            default: '0};
    @(negedge clk);
    evt = '0;
    io(IOD_OP_IO_WR, 8'h15, 8'h02);
    rdchk(8'h15, 8'h05);
    io(IOD_OP_IO_WR, 8'h15, 8'h00);
    rdchk(8'h15, 8'h05);
    io(IOD_OP_BIT_SET, 8'h15, 8'h02);
    rdchk(8'h15, 8'h01);
    io(IOD_OP_BIT_CLR, 8'h15, 8'h00);
    rdchk(8'h15, 8'h01);
    io(IOD_OP_BIT_SET, 8'h1C, 8'h01);
    rdchk(8'h1C, 8'h01);
    io(IOD_OP_DS_WR, 8'h50, 8'h01);
    rdchk(8'h30, 8'h31);
    io(IOD_OP_IO_WR, 8'h30, 8'h10);
    rdchk(8'h30, 8'h20);
    rdchk(8'h17, 8'h02);
    rdchk(8'h1B, 8'h04);
    io(IOD_OP_IO_WR, 8'h1F, 8'h03);
    rdchk(8'h1F, 8'h03);
    @(negedge clk);
    evt = '{eeprom_done: 1'b1, default: '0};
    @(negedge clk);
    evt = '0;
    rdchk(8'h1F, 8'h00);
  endtask : t_flags

  task automatic t_ext;
    io(IOD_OP_DS_WR, 8'h80, 8'h11);
    chk4(fl, 4'b1000);
    chk8(ext_seen[15:8], 8'h80);
    chk8(ext_seen[7:0], 8'h11);
    io(IOD_OP_DS_RD, 8'hFF);
    chk8(rd, 8'h5A);
    chk4({3'b000, ext_seen[16]}, 4'b0001);
    io(IOD_OP_IO_WR, 8'h60, 8'h44);
    chk4(fl, 4'b0000);
    chk8(ext_seen[15:8], 8'hFF);
    chk8(ctrl.ee_data, 8'h44);
    io(IOD_OP_IO_WR, 8'h25, 8'hC3);
    chk4({2'b00, force_cmp}, 4'b0011);
    rdchk(8'h25, 8'h03);
  endtask : t_ext

  task automatic t_rsv;
    io(IOD_OP_IO_WR, 8'h01, 8'hFF, 1'b1);
    rdchk(8'h01, 8'h00);
    io(IOD_OP_DS_WR, 8'h49, 8'hFF, 1'b1);
    io(IOD_OP_DS_RD, 8'h49);
    chk8(rd, 8'h00);
    io(IOD_OP_IO_WR, 8'h07, 8'hFF, 1'b1);
    rdchk(8'h07, 8'h7F);
  endtask : t_rsv

  initial begin
    rstn = 1'b0;
    pin_b = 8'hC3;
    pin_c = 7'h55;
    pin_d = 8'h0F;
    comparator_out = 1'b1;
    evt = '0;
    spi_flag = 1'b1;
    spi_collision = 1'b0;
    ext_rdata = 8'h5A;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_pins();
    t_alias();
    t_bits();
    t_skip();
    t_flags();
    t_ext();
    t_rsv();
    results();
  end
endmodule : iod_io_space_tb
